/* File: src/dmr_mode_regs.sv */
// Mode and extended mode register block of a DDR memory device.
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dmr_defines.svh"
module dmr_mode_regs #(
  parameter int LOCK_CYCLES = `DMR_LOCK_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire dmr_pkg::dmr_cmd_t     cmd,
  input  wire logic [`DMR_AV_W-1:0]  avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output dmr_pkg::dmr_base_t         base_mode,
  output dmr_pkg::dmr_ext_t          ext_mode,
  output logic                       dll_enabled,
  output logic                       dll_locking,
  output logic                       reserved_seen
);
  typedef struct packed {
    dmr_pkg::dmr_base_t base;
    dmr_pkg::dmr_ext_t  ext;
    logic               dll_en;
    logic               locking;
    logic               rsv;
    logic               ack;
    logic [31:0]        rdata;
  } dmr_state_t;
  dmr_state_t st_q;
  dmr_state_t st_d;

  logic [5:0]         opm;
  logic               is_base;
  logic               is_ext;
  logic               tmr_start;
  logic               tmr_busy;
  dmr_pkg::dmr_mode_t mode;

  assign opm     = cmd.addr[`DMR_OPM_MSB:`DMR_OPM_LSB];
  assign is_base = cmd.mrs && (cmd.ba == `DMR_BA_BASE);
  assign is_ext  = cmd.mrs && (cmd.ba == `DMR_BA_EXT);

  always_comb
  begin
    if (opm == `DMR_OPM_NORMAL)
    begin
      mode = dmr_pkg::DMR_NORMAL;
    end
    else if (opm == `DMR_OPM_DLLRST)
    begin
      mode = dmr_pkg::DMR_DLL_RESET;
    end
    else
    begin
      mode = dmr_pkg::DMR_RESERVED;
    end
  end

  assign tmr_start = is_base && (mode == dmr_pkg::DMR_DLL_RESET)
                     && st_q.dll_en;

  dmr_lock_timer #(
    .CYCLES (LOCK_CYCLES)
  ) u_lock (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (tmr_start),
    .busy    (tmr_busy)
  );

  always_comb
  begin
    st_d         = st_q;
    st_d.locking = tmr_busy;
    st_d.ack     = 1'b0;
    if (is_base)
    begin
      case (mode)
        dmr_pkg::DMR_NORMAL, dmr_pkg::DMR_DLL_RESET:
        begin
          st_d.base.burst_len  = cmd.addr[`DMR_BL_MSB:`DMR_BL_LSB];
          st_d.base.burst_type = cmd.addr[`DMR_BT_BIT];
          st_d.base.read_lat   = cmd.addr[`DMR_CL_MSB:`DMR_CL_LSB];
        end
        default:
        begin
          st_d.rsv = 1'b1;
        end
      endcase
    end
    else if (is_ext)
    begin
      st_d.ext.dll_disable         = cmd.addr[`DMR_EXT_DLLDIS];
      st_d.ext.output_drive_select = cmd.addr[`DMR_EXT_DRVSEL];
      st_d.dll_en                  = !cmd.addr[`DMR_EXT_DLLDIS];
    end
    if (cmd.self_ref_exit && !is_ext)
    begin
      st_d.dll_en          = 1'b1;
      st_d.ext.dll_disable = 1'b0;
    end
    if ((avs_read || avs_write) && !st_q.ack)
    begin
      st_d.ack = 1'b1;
      if (avs_address == `DMR_ADR_BASE)
      begin
        st_d.rdata = {25'h0, st_q.base};
      end
      else if (avs_address == `DMR_ADR_EXT)
      begin
        st_d.rdata = {30'h0, st_q.ext};
      end
      else if (avs_address == `DMR_ADR_STAT)
      begin
        st_d.rdata = {29'h0, st_q.rsv, st_q.locking, st_q.dll_en};
      end
      else
      begin
        st_d.rdata = 32'h0;
      end
    end
    // A write lands at the edge that ends the transfer.
    if (avs_write && st_q.ack && (avs_address == `DMR_ADR_STAT)
        && avs_writedata[`DMR_STAT_RSV_BIT])
    begin
      st_d.rsv = 1'b0;
    end
    if (is_base && mode == dmr_pkg::DMR_RESERVED)
    begin
      st_d.rsv = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_q.dll_en    <= 1'b0;
      st_q.locking   <= 1'b0;
      st_q.rsv       <= 1'b0;
      st_q.ack       <= 1'b0;
      st_q.rdata     <= 32'h0;
      st_q.base      <= '0;
      st_q.ext       <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = !st_q.ack;
  assign base_mode       = st_q.base;
  assign ext_mode        = st_q.ext;
  assign dll_enabled     = st_q.dll_en;
  assign dll_locking     = st_q.locking;
  assign reserved_seen   = st_q.rsv;

  a_lock_start_busy: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    tmr_start |=> ##1 dll_locking)
    else $error("lock wait not started");
  a_base_load: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    is_base && mode == dmr_pkg::DMR_NORMAL
    |=> base_mode.burst_len == $past(cmd.addr[`DMR_BL_MSB:`DMR_BL_LSB])
        && base_mode.burst_type == $past(cmd.addr[`DMR_BT_BIT])
        && base_mode.read_lat == $past(cmd.addr[`DMR_CL_MSB:`DMR_CL_LSB]))
    else $error("base not loaded");
  a_ext_load: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    is_ext
    |=> ext_mode.dll_disable == $past(cmd.addr[`DMR_EXT_DLLDIS])
        && ext_mode.output_drive_select == $past(cmd.addr[`DMR_EXT_DRVSEL]))
    else $error("ext not loaded");
  a_ext_hold: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !is_ext && !cmd.self_ref_exit |=> $stable(ext_mode))
    else $error("ext changed");
  a_srx_dll_on: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    cmd.self_ref_exit && !is_ext |=> dll_enabled)
    else $error("loop not re-enabled");
  a_base_hold: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    !is_base |=> $stable(base_mode))
    else $error("base changed");
  a_rsv_flag: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    is_base && mode == dmr_pkg::DMR_RESERVED
    |=> reserved_seen && $stable(base_mode))
    else $error("reserved not flagged");
  a_dll_bit: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    is_ext |=> dll_enabled == !$past(cmd.addr[`DMR_EXT_DLLDIS]))
    else $error("loop enable wrong");
endmodule : dmr_mode_regs

/* File: src/dmr_defines.svh */
// Constants for the DDR mode register programming block.
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH
`define DMR_ADDR_W       13
`define DMR_BA_W         2
`define DMR_BA_BASE      2'h0
`define DMR_BA_EXT       2'h1
`define DMR_BL_LSB       0
`define DMR_BL_MSB       2
`define DMR_BT_BIT       3
`define DMR_CL_LSB       4
`define DMR_CL_MSB       6
`define DMR_OPM_LSB      7
`define DMR_OPM_MSB      12
`define DMR_OPM_NORMAL   6'h00
`define DMR_OPM_DLLRST   6'h02
`define DMR_EXT_DLLDIS   0
`define DMR_EXT_DRVSEL   1
`define DMR_LOCK_CYCLES  200
`define DMR_CNT_W        8
`define DMR_AV_W         2
`define DMR_ADR_BASE     2'h0
`define DMR_ADR_EXT      2'h1
`define DMR_ADR_STAT     2'h2
`define DMR_STAT_RSV_BIT 2
`endif

/* File: src/dmr_pkg.sv */
// Types shared by the DDR mode register programming block.
package dmr_pkg;
  typedef struct packed {
    logic [2:0] burst_len;
    logic       burst_type;
    logic [2:0] read_lat;
  } dmr_base_t;
  typedef struct packed {
    logic dll_disable;
    logic output_drive_select;
  } dmr_ext_t;
  typedef struct packed {
    logic        mrs;
    logic        self_ref_exit;
    logic [1:0]  ba;
    logic [12:0] addr;
  } dmr_cmd_t;
  typedef enum logic [1:0] {
    DMR_NORMAL,
    DMR_DLL_RESET,
    DMR_RESERVED
  } dmr_mode_t;
endpackage : dmr_pkg

/* File: src/dmr_lock_timer.sv */
// Counts clock cycles after a loop reset until the loop is locked.
`timescale 1ns/1ns
`include "dmr_defines.svh"
module dmr_lock_timer #(
  parameter int CYCLES = `DMR_LOCK_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy
);
  typedef struct packed {
    logic [`DMR_CNT_W-1:0] cnt;
    logic                  busy;
  } dmr_tmr_t;
  dmr_tmr_t st_q;
  dmr_tmr_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (start)
    begin
      st_d.cnt  = CYCLES[`DMR_CNT_W-1:0];
      st_d.busy = 1'b1;
    end
    else if (st_q.busy)
    begin
      st_d.cnt = st_q.cnt - 1'b1;
      if (st_q.cnt == `DMR_CNT_W'(1))
      begin
        st_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign busy = st_q.busy;
endmodule : dmr_lock_timer

/* File: tb/dmr_ctrl_model.sv */
// Memory controller model that issues mode register set commands.
`timescale 1ns/1ns
module dmr_ctrl_model #(
  parameter int TMRD = 2
) (
  input  wire logic         sys_clk,
  output dmr_pkg::dmr_cmd_t cmd
);
  initial cmd = '0;
  task mrs(input logic [1:0] ba, input logic [12:0] a);
    @(posedge sys_clk);
    cmd <= '{1'b1, 1'b0, ba, a};
    @(posedge sys_clk);
    cmd <= '{1'b0, 1'b0, ~ba, ~a};
    repeat (TMRD) @(posedge sys_clk);
  endtask : mrs
  task dll_on(input logic ds, input logic [6:0] b, input int lock);
    mrs(2'h1, {11'h000, ds, 1'b0});
    mrs(2'h0, {6'h02, b});
    repeat (lock) @(posedge sys_clk);
    mrs(2'h0, {6'h00, b});
  endtask : dll_on
  task sr_exit();
    @(posedge sys_clk);
    cmd.self_ref_exit <= 1'b1;
    @(posedge sys_clk);
    cmd.self_ref_exit <= 1'b0;
  endtask : sr_exit
endmodule : dmr_ctrl_model

/* File: tb/tb_dmr_mode_regs.sv */
// Self-checking bench for the mode register block.
`timescale 1ns/1ns
module tb_dmr_mode_regs;
  localparam int LOCK = 5;
  logic               sys_clk, resetn, avs_read, avs_write;
  logic               avs_waitrequest, dll_enabled, dll_locking;
  logic               reserved_seen, ds;
  logic [1:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata, seed, r;
  dmr_pkg::dmr_cmd_t  cmd;
  dmr_pkg::dmr_base_t base_mode;
  dmr_pkg::dmr_ext_t  ext_mode;
  logic [31:0]        exp_q[$];
  int                 error_cnt, n_compared, cyc, lock_n;
  dmr_mode_regs #(.LOCK_CYCLES(LOCK)) dmr_mode_regs_i (.sys_clk, .resetn,
    .cmd, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .base_mode, .ext_mode, .dll_enabled,
    .dll_locking, .reserved_seen);
  dmr_ctrl_model dmr_ctrl_model_i (.sys_clk, .cmd);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function logic [31:0] bexp(input logic [6:0] a);
    return {25'h0, a[2:0], a[3], a[6:4]};
  endfunction : bexp
  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task av(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task rd(input logic [1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    av(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge sys_clk)
  begin
    cyc++;
    if (dll_locking === 1'b1)
      lock_n++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      cmp("readdata", exp_q.pop_front(), avs_readdata);
    if (cyc == 3000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    seed = 32'h60FD;
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    r = $random(seed);
    ds = r[7];
    lock_n = 0;
    dmr_ctrl_model_i.dll_on(ds, r[6:0], LOCK);
    cmp("lock_cycles", LOCK, lock_n);
    rd(2'h1, {30'h0, 1'b0, ds});
    rd(2'h2, 32'h1);
    cmp("dll_enabled", 32'h1, {31'h0, dll_enabled});
    $display("test loop reset done");
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      dmr_ctrl_model_i.mrs(2'h0, {6'h00, r[6:0]});
      rd(2'h0, bexp(r[6:0]));
    end
    rd(2'h1, {30'h0, 1'b0, ds});
    cmp("base_mode", bexp(r[6:0]), {25'h0, base_mode});
    $display("test base register done");
    dmr_ctrl_model_i.mrs(2'h0, {6'h01, ~r[6:0]});
    rd(2'h0, bexp(r[6:0]));
    rd(2'h2, 32'h5);
    cmp("reserved_seen", 32'h1, {31'h0, reserved_seen});
    av(1'b1, 2'h2, 32'h4);
    rd(2'h2, 32'h1);
    av(1'b1, 2'h3, r);
    rd(2'h3, 32'h0);
    $display("test reserved mode done");
    dmr_ctrl_model_i.mrs(2'h1, {11'h000, 2'b11});
    rd(2'h1, 32'h3);
    cmp("ext_mode", 32'h3, {30'h0, ext_mode});
    rd(2'h2, 32'h0);
    dmr_ctrl_model_i.mrs(2'h0, {6'h02, ~r[6:0]});
    rd(2'h0, bexp(~r[6:0]));
    rd(2'h2, 32'h0);
    dmr_ctrl_model_i.mrs(2'h0, {6'h00, ~r[6:0]});
    dmr_ctrl_model_i.sr_exit();
    rd(2'h2, 32'h1);
    rd(2'h1, 32'h1);
    cmp("dll_enabled", 32'h1, {31'h0, dll_enabled});
    lock_n = 0;
    dmr_ctrl_model_i.dll_on(ds, r[6:0], LOCK);
    cmp("lock_cycles", LOCK, lock_n);
    $display("test extended register done");
    tally_and_finish();
  end
endmodule : tb_dmr_mode_regs
